// file: verilog/smbio_defines.svh
// constants for the smbus i/o expander core
`ifndef SMBIO_DEFINES_SVH
`define SMBIO_DEFINES_SVH
`define SMBIO_CMD_NLEV   8'h00
`define SMBIO_CMD_NRISE  8'h01
`define SMBIO_CMD_NFALL  8'h02
`define SMBIO_CMD_SLEV   8'h03
`define SMBIO_CMD_SRISE  8'h04
`define SMBIO_CMD_SFALL  8'h05
`define SMBIO_CMD_STATUS 8'h06
`define SMBIO_CMD_RESAMP 8'h07
`define SMBIO_CMD_SWRST  8'h08
`define SMBIO_CMD_MAKER  8'hFE
`define SMBIO_RST_LEV_LOW 8'h00
`define SMBIO_RST_LEV_HIZ 8'hFF
`define SMBIO_RST_MASK    8'hFF
`define SMBIO_ALERT_ADDR  7'h0C
`endif

// file: verilog/smbio_pkg.sv
// types for the smbus i/o expander core
package smbio_pkg;
  typedef logic [7:0] smbio_byte_t;
  typedef enum logic [7:0] {
    SMBIO_IDLE  = 8'h01,
    SMBIO_ADDR  = 8'h02,
    SMBIO_AACK  = 8'h04,
    SMBIO_WRX   = 8'h08,
    SMBIO_WACK  = 8'h10,
    SMBIO_TX    = 8'h20,
    SMBIO_TACK  = 8'h40,
    SMBIO_SKIP  = 8'h80
  } smbio_state_t;
endpackage : smbio_pkg

// file: verilog/smbio_edge_latch.sv
// per-pin edge detector and pending interrupt flag
`timescale 1ns/10ps
module smbio_edge_latch #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // pins and masks
  input  wire logic [WIDTH-1:0] pin_in,
  input  wire logic [WIDTH-1:0] rise_mask,
  input  wire logic [WIDTH-1:0] fall_mask,
  // control
  input  wire logic             clear,
  output logic                  pending
);
  logic [WIDTH-1:0] last_pin;
  logic [WIDTH-1:0] hit;
  logic             next_pending;

  // rise and fall gated per bit
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      assign hit[g] = (pin_in[g] & ~last_pin[g] & ~rise_mask[g]) |
                      (~pin_in[g] & last_pin[g] & ~fall_mask[g]);
    end
  endgenerate

  assign next_pending = (|hit) | (pending & ~clear);

  // last_pin resets high-less: first sample after reset may flag an edge, masks start set
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      last_pin <= '0;
      pending  <= 1'b0;
    end else begin
      last_pin <= pin_in;
      pending  <= next_pending;
    end
  end
endmodule : smbio_edge_latch

// file: verilog/smbio_core.sv
// smbus i/o expander register, bus slave and alert core
`timescale 1ns/10ps
`include "smbio_defines.svh"
module smbio_core #(
  parameter int          WIDTH      = 8,
  parameter bit          HIZ_VARIANT = 1'b0,
  parameter logic [7:0]  MAKER_ID   = 8'hA5, // arbitrary value
  parameter logic [6:0]  ADDR_BASE  = 7'h10
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              uvlo,
  // smbus pins, sampled synchronously
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  // address straps and mode
  input  wire logic [3:0]        addr_sel,
  input  wire logic              suspend_select_in,
  input  wire logic              thermal_fault,
  // i/o pins
  input  wire logic [WIDTH-1:0]  io_in,
  output logic [WIDTH-1:0]       io_out,
  output logic [WIDTH-1:0]       io_oe,
  // alert pin
  output logic                   alert_out,
  output logic                   alert_oe,
  // observed state
  output logic [6:0]             slave_addr
);
  import smbio_pkg::*;

  smbio_state_t state;
  smbio_state_t next_state;
  smbio_byte_t  normal_output_levels;
  smbio_byte_t  normal_rise_mask;
  smbio_byte_t  normal_fall_mask;
  smbio_byte_t  suspend_output_levels;
  smbio_byte_t  suspend_rise_mask;
  smbio_byte_t  suspend_fall_mask;
  smbio_byte_t  cmd;
  smbio_byte_t  shreg;
  smbio_byte_t  txreg;
  logic [3:0]   bitcnt;
  logic [1:0]   bytecnt;
  logic         is_read;
  logic         is_alert;
  logic         scl_d;
  logic         sda_d;
  logic         resample;
  logic         sw_reset;
  logic         pending;
  logic         alert_won;
  logic         alert_clear;

  localparam smbio_byte_t RST_LEV = HIZ_VARIANT ? `SMBIO_RST_LEV_HIZ : `SMBIO_RST_LEV_LOW;

  // bus conditions
  wire scl_rise   = scl_in & ~scl_d;
  wire scl_fall   = ~scl_in & scl_d;
  wire start_cond = scl_in & scl_d & sda_d & ~sda_in;
  wire stop_cond  = scl_in & scl_d & ~sda_d & sda_in;
  wire [6:0] strap_addr = ADDR_BASE + {3'h0, addr_sel};
  wire [7:0] rx_byte  = {shreg[6:0], sda_in};
  // matched on the ninth falling edge, when shreg holds the whole byte
  wire addr_match  = (shreg[7:1] == slave_addr);
  wire alert_match = (shreg[7:1] == `SMBIO_ALERT_ADDR) & shreg[0] & pending;

  wire smbio_byte_t act_lev  = suspend_select_in ? normal_output_levels : suspend_output_levels;
  wire smbio_byte_t act_rise = suspend_select_in ? normal_rise_mask : suspend_rise_mask;
  wire smbio_byte_t act_fall = suspend_select_in ? normal_fall_mask : suspend_fall_mask;

  // register read decode, used for both read paths
  function automatic smbio_byte_t read_reg(input smbio_byte_t c);
    unique case (c)
      `SMBIO_CMD_NLEV:   read_reg = normal_output_levels;
      `SMBIO_CMD_NRISE:  read_reg = normal_rise_mask;
      `SMBIO_CMD_NFALL:  read_reg = normal_fall_mask;
      `SMBIO_CMD_SLEV:   read_reg = suspend_output_levels;
      `SMBIO_CMD_SRISE:  read_reg = suspend_rise_mask;
      `SMBIO_CMD_SFALL:  read_reg = suspend_fall_mask;
      `SMBIO_CMD_STATUS: read_reg = io_in;
      `SMBIO_CMD_MAKER:  read_reg = MAKER_ID;
      default:           read_reg = 8'h00;
    endcase
  endfunction : read_reg

  // write target test; unmapped codes other than redirects are ignored
  function automatic logic is_redirect(input smbio_byte_t c);
    is_redirect = (c == `SMBIO_CMD_STATUS) || (c == `SMBIO_CMD_RESAMP) ||
                  (c == `SMBIO_CMD_SWRST) || (c == `SMBIO_CMD_MAKER);
  endfunction : is_redirect

  // byte ends on the fall after its eighth bit, so the ack lands in the ninth low phase
  wire ack_bit_done = (bitcnt == 4'h8) & scl_fall;
  wire cmd_byte     = (bytecnt == 2'h1);
  wire data_wr      = (state == SMBIO_WACK) & scl_fall & (bytecnt == 2'h2);
  wire cmd_rx       = (state == SMBIO_WACK) & scl_fall & cmd_byte;
  wire cmd_resamp = cmd_rx & ((shreg == `SMBIO_CMD_RESAMP) | (shreg == `SMBIO_CMD_SWRST));
  wire cmd_swrst  = cmd_rx & (shreg == `SMBIO_CMD_SWRST);
  // lost arbitration: driving high while bus low
  wire arb_lost   = (state == SMBIO_TX) & is_alert & scl_rise & txreg[7] & ~sda_in;

  // next state of the byte engine
  always_comb begin
    next_state = state;
    unique case (state)
      SMBIO_IDLE: next_state = state;
      SMBIO_ADDR: if (ack_bit_done) next_state = (addr_match | alert_match) ? SMBIO_AACK : SMBIO_SKIP;
      SMBIO_AACK: if (scl_fall) next_state = is_read ? SMBIO_TX : SMBIO_WRX;
      SMBIO_WRX:  if (ack_bit_done) next_state = SMBIO_WACK;
      SMBIO_WACK: if (scl_fall) next_state = SMBIO_WRX;
      SMBIO_TX:   if (arb_lost) next_state = SMBIO_SKIP;
                  else if (ack_bit_done) next_state = SMBIO_TACK;
      SMBIO_TACK: if (scl_rise) next_state = sda_in ? SMBIO_SKIP : SMBIO_TX;
      SMBIO_SKIP: next_state = state;
    endcase
    if (start_cond) next_state = SMBIO_ADDR;
    else if (stop_cond) next_state = SMBIO_IDLE;
  end

  // byte engine: shift, count, address ack handling
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state    <= SMBIO_IDLE;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
      shreg    <= 8'h00;
      txreg    <= 8'hFF;
      bitcnt   <= 4'h0;
      bytecnt  <= 2'h0;
      is_read  <= 1'b0;
      is_alert <= 1'b0;
    end else begin
      scl_d <= scl_in;
      sda_d <= sda_in;
      state <= next_state;
      if (start_cond) begin
        bitcnt <= 4'h0;
      end else if (scl_rise && bitcnt != 4'h8 && state != SMBIO_TX) begin
        shreg  <= rx_byte;
        bitcnt <= bitcnt + 4'h1;
      end
      if (state == SMBIO_ADDR && ack_bit_done) begin
        is_read  <= shreg[0];
        is_alert <= alert_match & ~addr_match;
      end
      if (state == SMBIO_AACK && scl_fall) begin
        bitcnt  <= 4'h0;
        bytecnt <= 2'h1;
        txreg   <= is_alert ? {slave_addr, 1'b1} : read_reg(cmd);
      end else if (state == SMBIO_WACK && scl_fall) begin
        bitcnt  <= 4'h0;
        bytecnt <= (bytecnt == 2'h3) ? 2'h3 : bytecnt + 2'h1;
      end else if (state == SMBIO_TX) begin
        // count on rise, shift on fall: sda must only move while scl is low
        if (scl_rise && !arb_lost) bitcnt <= bitcnt + 4'h1;
        if (scl_fall) txreg <= {txreg[6:0], 1'b1};
      end else if (state == SMBIO_TACK && scl_rise) begin
        bitcnt <= 4'h0;
        txreg  <= read_reg(cmd);
      end
    end
  end

  // clear when alert byte fully sent and won, or on software reset
  assign alert_won   = is_alert & (state == SMBIO_TX) & ack_bit_done & ~arb_lost;
  assign alert_clear = alert_won | sw_reset;

  // command and register writes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmd      <= 8'h00;
      resample <= 1'b1;
      sw_reset <= 1'b0;
    end else begin
      resample <= cmd_resamp;
      sw_reset <= cmd_swrst;
      if (cmd_rx) cmd <= shreg;
    end
  end

  wire reg_rstn = rstn & ~uvlo;

  // register file; software reset acts as synchronous clear
  always_ff @(posedge core_clk or negedge reg_rstn) begin
    if (!reg_rstn) begin
      normal_output_levels  <= RST_LEV;
      suspend_output_levels <= RST_LEV;
      normal_rise_mask      <= `SMBIO_RST_MASK;
      normal_fall_mask      <= `SMBIO_RST_MASK;
      suspend_rise_mask     <= `SMBIO_RST_MASK;
      suspend_fall_mask     <= `SMBIO_RST_MASK;
    end else if (sw_reset) begin
      normal_output_levels  <= RST_LEV;
      suspend_output_levels <= RST_LEV;
      normal_rise_mask      <= `SMBIO_RST_MASK;
      normal_fall_mask      <= `SMBIO_RST_MASK;
      suspend_rise_mask     <= `SMBIO_RST_MASK;
      suspend_fall_mask     <= `SMBIO_RST_MASK;
    end else if (data_wr) begin
      if (cmd == `SMBIO_CMD_NLEV || is_redirect(cmd)) normal_output_levels <= shreg;
      if (cmd == `SMBIO_CMD_NRISE) normal_rise_mask      <= shreg;
      if (cmd == `SMBIO_CMD_NFALL) normal_fall_mask      <= shreg;
      if (cmd == `SMBIO_CMD_SLEV)  suspend_output_levels <= shreg;
      if (cmd == `SMBIO_CMD_SRISE) suspend_rise_mask     <= shreg;
      if (cmd == `SMBIO_CMD_SFALL) suspend_fall_mask     <= shreg;
    end
  end

  // address strap capture, clocked after release
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      slave_addr <= 7'h00;
    end else if (resample) begin
      slave_addr <= strap_addr;
    end
  end

  // clearing touches only the pending flag
  smbio_edge_latch #(
    .WIDTH     (WIDTH)
  ) u_edge (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .pin_in    (io_in),
    .rise_mask (act_rise),
    .fall_mask (act_fall),
    .clear     (alert_clear),
    .pending   (pending)
  );

  // pin-side outputs, registered
  wire sda_drive = ((state == SMBIO_AACK) | (state == SMBIO_WACK)) |
                   ((state == SMBIO_TX) & ~txreg[7]);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      io_out    <= '0;
      io_oe     <= '0;
      sda_out   <= 1'b0;
      sda_oe    <= 1'b0;
      alert_out <= 1'b0;
      alert_oe  <= 1'b0;
    end else begin
      io_out    <= '0;
      // zero pulls low; thermal fault releases all
      io_oe     <= ~act_lev & {WIDTH{~thermal_fault}};
      sda_out   <= 1'b0;
      sda_oe    <= sda_drive & ~arb_lost;
      alert_out <= 1'b0;
      // alert low on pending or fault
      alert_oe  <= pending | thermal_fault;
    end
  end
endmodule : smbio_core

// file: test/smbio_core_monitor.sv
// assertion checker for the smbus i/o expander core
`timescale 1ns/10ps
module smbio_core_monitor #(
  parameter int         WIDTH     = 8,
  parameter logic [6:0] ADDR_BASE = 7'h10
) (
  // clock and reset
  input wire logic             core_clk,
  input wire logic             rstn,
  input wire logic             uvlo,
  // bus
  input wire logic             scl_in,
  input wire logic             sda_in,
  input wire logic             sda_out,
  input wire logic             sda_oe,
  // straps and mode
  input wire logic [3:0]       addr_sel,
  input wire logic             suspend_select_in,
  input wire logic             thermal_fault,
  // pins
  input wire logic [WIDTH-1:0] io_in,
  input wire logic [WIDTH-1:0] io_out,
  input wire logic [WIDTH-1:0] io_oe,
  input wire logic             alert_out,
  input wire logic             alert_oe,
  input wire logic [6:0]       slave_addr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [7:0] quiet;
  logic       susp_q;
  // cycles since the last bus drive, mode change, uvlo or thermal fault; saturates, never wraps
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      quiet  <= 8'h00;
      susp_q <= 1'b1;
    end else begin
      susp_q <= suspend_select_in;
      if (sda_oe || uvlo || thermal_fault || suspend_select_in != susp_q) quiet <= 8'h00;
      else if (quiet != 8'hFF) quiet <= quiet + 8'h01;
    end
  end
  sequence s_hot; thermal_fault [*3]; endsequence
  sequence s_drive; sda_oe [*4]; endsequence
  property p_thermal_alert; s_hot |-> alert_oe; endproperty
  a_thermal_alert: assert property (p_thermal_alert) else $error("no alert on fault");
  property p_open_drain; io_out == '0 && !sda_out && !alert_out; endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin driven high");
  property p_sda_scl_low; $changed(sda_oe) |-> !scl_in; endproperty
  a_sda_scl_low: assert property (p_sda_scl_low) else $error("sda moved, scl high");
  property p_drive_hold; $rose(sda_oe) |-> s_drive; endproperty
  a_drive_hold: assert property (p_drive_hold) else $error("sda drive too short");
  property p_alert_fall; $fell(alert_oe) |-> quiet < 8'h78; endproperty
  a_alert_fall: assert property (p_alert_fall) else $error("alert cleared idle");
  property p_addr_change; $changed(slave_addr) && $past(rstn) |-> quiet < 8'h78; endproperty
  a_addr_change: assert property (p_addr_change) else $error("address moved idle");
  property p_addr_load; rstn && !$past(rstn) |=> slave_addr == ADDR_BASE + {3'h0, addr_sel};
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("bad strap address");
  property p_io_steady; $changed(io_oe) |-> quiet < 8'h78; endproperty
  a_io_steady: assert property (p_io_steady) else $error("pins moved idle");
endmodule : smbio_core_monitor

// file: test/smbio_host_model.sv
// bit-level smbus host used to drive the core
`timescale 1ns/10ps
module smbio_host_model (
  // clock
  input  wire logic core_clk,
  // wired sda level
  input  wire logic sda_line,
  // host drive, 1 releases the line
  output logic      scl_o,
  output logic      sda_o
);
  initial scl_o = 1'b1;
  initial sda_o = 1'b1;
  // every change lands one step after a rising edge
  task automatic put(input logic c, input logic d, input int n);
    scl_o = c;
    sda_o = d;
    repeat (n) @(posedge core_clk);
    #1;
  endtask : put
  // sda moves only after scl has been low a cycle, so no false start
  task automatic bitx(input logic b, output logic r);
    put(1'b0, sda_o, 1);
    put(1'b0, b, 3);
    put(1'b1, b, 4);
    r = sda_line;
  endtask : bitx
  // msb first, ninth bit released
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(1'b1, nak);
  endtask : xfer
  // start is cond(1,0), stop is cond(0,1)
  task automatic cond(input logic first, input logic last);
    put(1'b0, sda_o, 1);
    put(1'b0, first, 3);
    put(1'b1, first, 4);
    put(1'b1, last, 4);
  endtask : cond
  // kind 0 write, 1 send, 2 read, 3 alert query; d doubles as a rival's reply
  task automatic txn(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                     input int kind, output logic [7:0] q, output logic nak);
    logic       n0, n1, n2;
    logic [7:0] x;
    cond(1'b1, 1'b0);
    if (kind == 3) xfer(8'h19, x, n0);
    else xfer({a, 1'b0}, x, n0);
    n1 = 1'b0;
    if (kind < 3) xfer(c, x, n1);
    if (kind == 2) begin
      cond(1'b1, 1'b0);
      xfer({a, 1'b1}, x, n2);
      n1 = n1 | n2;
    end
    n2 = 1'b0;
    q = x;
    if (kind != 1) xfer(d, q, n2);
    cond(1'b0, 1'b1);
    nak = n0 | n1 | (kind == 0 && n2);
  endtask : txn
endmodule : smbio_host_model

// file: test/tb_smbio_core.sv
// self-checking bench for the smbus i/o expander core
`timescale 1ns/10ps
module tb_smbio_core;
  localparam logic [7:0] MAKER = 8'h6B; // arbitrary value
  logic            core_clk, rstn, uvlo, suspend_select_in, thermal_fault;
  logic            scl_o, sda_o, sda_out, sda_oe, alert_out, alert_oe, nak;
  logic [3:0]      addr_sel;
  logic [6:0]      slave_addr, sa;
  logic [7:0]      io_out, io_oe, ext_lvl, q;
  int              failures, cmp_count;
  // pull-ups on sda and on every pin
  wire logic       sda_in = sda_o & ~sda_oe;
  wire logic [7:0] io_in  = ext_lvl & ~io_oe;
  // {command, reset value, written value}
  localparam logic [23:0] ROWS [6] = '{24'h00005A, 24'h01FF3C, 24'h02FFC3,
                                       24'h03000F, 24'h04FFF0, 24'h05FF11};
  localparam logic [7:0]  RDIR [3] = '{8'h06, 8'h07, 8'hFE};
  smbio_core #(.MAKER_ID(MAKER)) dut_u (
    .core_clk(core_clk), .rstn(rstn), .uvlo(uvlo), .scl_in(scl_o), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel),
    .suspend_select_in(suspend_select_in), .thermal_fault(thermal_fault), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .alert_out(alert_out), .alert_oe(alert_oe),
    .slave_addr(slave_addr));
  smbio_host_model host_u (.core_clk(core_clk), .sda_line(sda_in), .scl_o(scl_o),
    .sda_o(sda_o));
  task automatic complete_run();
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    host_u.txn(sa, c, d, 0, q, nak);
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [7:0] exp);
    host_u.txn(sa, c, 8'hFF, 2, q, nak);
    chk(q, exp);
  endtask : rd
  // bounded wait for the alert level, then compare it
  task automatic alert_is(input logic e);
    for (int i = 0; i < 20 && alert_oe !== e; i++) @(posedge core_clk);
    #1;
    chk({7'h00, alert_oe}, {7'h00, e});
  endtask : alert_is
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // about seven times the length of the run
  initial begin
    #400000;
    failures++;
    complete_run();
  end
  initial begin
    {rstn, uvlo, thermal_fault, suspend_select_in, ext_lvl} = {4'b0001, 8'hFF};
    {addr_sel, sa} = {4'h3, 7'h13};
    repeat (5) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    host_u.put(1'b1, 1'b1, 3);
    foreach (ROWS[i]) begin
      rd(ROWS[i][23:16], ROWS[i][15:8]);
      wr(ROWS[i][23:16], ROWS[i][7:0]);
      rd(ROWS[i][23:16], ROWS[i][7:0]);
    end
    chk(io_oe, 8'hA5);
    suspend_select_in = 1'b0;
    host_u.put(1'b1, 1'b1, 3);
    chk(io_oe, 8'hF0);
    suspend_select_in = 1'b1;
    host_u.put(1'b1, 1'b1, 3);
    rd(8'hFE, MAKER);
    rd(8'h06, 8'h5A);
    foreach (RDIR[i]) begin
      wr(RDIR[i], 8'(8'h30 + i));
      rd(8'h00, 8'(8'h30 + i));
    end
    // unmapped command leaves the register file alone
    wr(8'h40, 8'h99);
    rd(8'h00, 8'h32);
    addr_sel = 4'h5;
    host_u.txn(sa, 8'h08, 8'h00, 1, q, nak);
    sa = 7'h15;
    chk({1'b0, slave_addr}, 8'h15);
    rd(8'h00, 8'h00);
    rd(8'h02, 8'hFF);
    alert_is(1'b0);
    addr_sel = 4'h2;
    host_u.txn(sa, 8'h07, 8'h00, 1, q, nak);
    sa = 7'h12;
    chk({1'b0, slave_addr}, 8'h12);
    wr(8'h00, 8'hFF);
    alert_is(1'b0);
    wr(8'h02, 8'hFE);
    ext_lvl[0] = 1'b0;
    alert_is(1'b1);
    wr(8'h02, 8'hFF);
    alert_is(1'b1);
    // a rival at a lower address wins the alert reply
    host_u.txn(sa, 8'h00, 8'h21, 3, q, nak);
    chk(q, 8'h21);
    alert_is(1'b1);
    host_u.txn(sa, 8'h00, 8'hFF, 3, q, nak);
    chk(q, 8'h25);
    alert_is(1'b0);
    rd(8'h02, 8'hFF);
    wr(8'h01, 8'hFE);
    ext_lvl[0] = 1'b1;
    alert_is(1'b1);
    thermal_fault = 1'b1;
    alert_is(1'b1);
    thermal_fault = 1'b0;
    host_u.txn(sa, 8'h08, 8'h00, 1, q, nak);
    alert_is(1'b0);
    wr(8'h00, 8'hC3);
    uvlo = 1'b1;
    host_u.put(1'b1, 1'b1, 2);
    uvlo = 1'b0;
    rd(8'h00, 8'h00);
    complete_run();
  end
endmodule : tb_smbio_core
bind smbio_core smbio_core_monitor #(.WIDTH(WIDTH), .ADDR_BASE(ADDR_BASE)) mon_u (
  .core_clk(core_clk), .rstn(rstn), .uvlo(uvlo), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel),
  .suspend_select_in(suspend_select_in), .thermal_fault(thermal_fault), .io_in(io_in),
  .io_out(io_out), .io_oe(io_oe), .alert_out(alert_out), .alert_oe(alert_oe),
  .slave_addr(slave_addr));
